/* File: periph_clock_gate_pkg.sv */
package periph_clock_gate_pkg;

	localparam int          ADDR_W              = 8;
	localparam int          DATA_W              = 32;
	localparam int          BE_W                = 4;
	localparam int          INDEX_W             = 5;

	// Byte addresses of the two gate registers
	localparam logic [7:0]  BUS2_GATE_OFFSET    = 8'h18;
	localparam logic [7:0]  BUS1_GATE_OFFSET    = 8'h1c;

	localparam logic [31:0] BUS2_GATE_RESET     = 32'h0000_0000;
	localparam logic [31:0] BUS1_GATE_RESET     = 32'h0000_0000;
	localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;
	localparam logic [31:0] ONE_BIT             = 32'h0000_0001;

	// Second gate register bit positions
	localparam int SYSCONF_COMPARATOR_CLK_EN_BIT    = 0;
	localparam int ADC_IF_CLK_EN_BIT                = 9;
	localparam int ADVANCED_TIMER_CLK_EN_BIT        = 11;
	localparam int SERIAL_PERIPH_A_CLK_EN_BIT       = 12;
	localparam int SERIAL_PORT_A_CLK_EN_BIT         = 14;
	localparam int GENERAL_TIMER_FIFTEEN_CLK_EN_BIT = 16;
	localparam int GENERAL_TIMER_SIXTEEN_CLK_EN_BIT = 17;
	localparam int GENERAL_TIMER_SEVENTEEN_CLK_EN_BIT = 18;
	localparam int DEBUG_UNIT_CLK_EN_BIT            = 22;

	// First gate register bit positions
	localparam int TIMER_TWO_CLK_EN_BIT             = 0;
	localparam int TIMER_THREE_CLK_EN_BIT           = 1;
	localparam int BASIC_TIMER_CLK_EN_BIT           = 4;
	localparam int TIMER_FOURTEEN_CLK_EN_BIT        = 8;
	localparam int WINDOWED_WATCHDOG_CLK_EN_BIT     = 11;
	localparam int SERIAL_PERIPH_B_CLK_EN_BIT       = 14;
	localparam int SERIAL_PORT_B_CLK_EN_BIT         = 17;
	localparam int TWO_WIRE_A_CLK_EN_BIT            = 21;
	localparam int TWO_WIRE_B_CLK_EN_BIT            = 22;
	localparam int POWER_INTERFACE_CLK_EN_BIT       = 28;
	localparam int DAC_CLK_EN_BIT                   = 29;
	localparam int CEC_CLK_EN_BIT                   = 30;

	localparam logic [31:0] BUS2_GATE_MASK =
		(ONE_BIT << SYSCONF_COMPARATOR_CLK_EN_BIT) |
		(ONE_BIT << ADC_IF_CLK_EN_BIT) |
		(ONE_BIT << ADVANCED_TIMER_CLK_EN_BIT) |
		(ONE_BIT << SERIAL_PERIPH_A_CLK_EN_BIT) |
		(ONE_BIT << SERIAL_PORT_A_CLK_EN_BIT) |
		(ONE_BIT << GENERAL_TIMER_FIFTEEN_CLK_EN_BIT) |
		(ONE_BIT << GENERAL_TIMER_SIXTEEN_CLK_EN_BIT) |
		(ONE_BIT << GENERAL_TIMER_SEVENTEEN_CLK_EN_BIT) |
		(ONE_BIT << DEBUG_UNIT_CLK_EN_BIT);

	localparam logic [31:0] BUS1_GATE_MASK =
		(ONE_BIT << TIMER_TWO_CLK_EN_BIT) |
		(ONE_BIT << TIMER_THREE_CLK_EN_BIT) |
		(ONE_BIT << BASIC_TIMER_CLK_EN_BIT) |
		(ONE_BIT << TIMER_FOURTEEN_CLK_EN_BIT) |
		(ONE_BIT << WINDOWED_WATCHDOG_CLK_EN_BIT) |
		(ONE_BIT << SERIAL_PERIPH_B_CLK_EN_BIT) |
		(ONE_BIT << SERIAL_PORT_B_CLK_EN_BIT) |
		(ONE_BIT << TWO_WIRE_A_CLK_EN_BIT) |
		(ONE_BIT << TWO_WIRE_B_CLK_EN_BIT) |
		(ONE_BIT << POWER_INTERFACE_CLK_EN_BIT) |
		(ONE_BIT << DAC_CLK_EN_BIT) |
		(ONE_BIT << CEC_CLK_EN_BIT);

	// Peripheral-bus side of one bus: transfer outstanding plus a read being returned
	typedef struct packed {
		logic                busy;
		logic [INDEX_W-1:0]  rd_index;
		logic [DATA_W-1:0]   rdata;
	} pbus_rd_t;

endpackage

/* File: gated_clock_bank.sv */
`timescale 1ns/1ps

// Glitch-free gating: the enable is retimed on the falling edge, so it can only
// change while clk is low and the AND never cuts a high phase short.
module gated_clock_bank #(
	parameter int N = 32
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic [N-1:0]  en,
	output logic      [N-1:0]  gclk
);

	logic [N-1:0] en_low_reg;
	logic [N-1:0] en_low_next;

	always_comb
	begin
		en_low_next = en;
		if (!rst_n)
		begin
			en_low_next = '0;
		end
	end

	always_ff @(negedge clk)
	begin
		en_low_reg <= en_low_next;
	end

	assign gclk = {N{clk}} & en_low_reg;

endmodule // gated_clock_bank

/* File: periph_clock_gate.sv */
`timescale 1ns/1ps

module periph_clock_gate (
	input  wire logic                                        clk,
	input  wire logic                                        rst_n,
	input  wire logic [periph_clock_gate_pkg::ADDR_W-1:0]    av_address,
	input  wire logic                                        av_read,
	input  wire logic                                        av_write,
	input  wire logic [periph_clock_gate_pkg::BE_W-1:0]      av_byteenable,
	input  wire logic [periph_clock_gate_pkg::DATA_W-1:0]    av_writedata,
	output logic      [periph_clock_gate_pkg::DATA_W-1:0]    av_readdata,
	output logic                                             av_waitrequest,
	input  wire periph_clock_gate_pkg::pbus_rd_t             pbus2_in,
	input  wire periph_clock_gate_pkg::pbus_rd_t             pbus1_in,
	output logic      [periph_clock_gate_pkg::DATA_W-1:0]    pbus2_rdata_out,
	output logic      [periph_clock_gate_pkg::DATA_W-1:0]    pbus1_rdata_out,
	output logic      [periph_clock_gate_pkg::DATA_W-1:0]    bus2_gate_en,
	output logic      [periph_clock_gate_pkg::DATA_W-1:0]    bus1_gate_en,
	output logic      [periph_clock_gate_pkg::DATA_W-1:0]    bus2_gclk,
	output logic                                             comparator_gclk,
	output logic      [periph_clock_gate_pkg::DATA_W-1:0]    bus1_gclk
);

	localparam int DW = periph_clock_gate_pkg::DATA_W;

	logic [DW-1:0] bus2_clock_gate_reg;
	logic [DW-1:0] bus2_clock_gate_next;
	logic [DW-1:0] bus1_clock_gate_reg;
	logic [DW-1:0] bus1_clock_gate_next;
	logic          pbus2_busy_reg;
	logic          pbus2_busy_next;
	logic          pbus1_busy_reg;
	logic          pbus1_busy_next;
	logic [DW-1:0] pbus2_rdata_reg;
	logic [DW-1:0] pbus2_rdata_next;
	logic [DW-1:0] pbus1_rdata_reg;
	logic [DW-1:0] pbus1_rdata_next;
	logic          sel_bus2;
	logic          sel_bus1;
	logic          stall;
	logic          write_taken;
	logic [1:0]    comparator_gate;

	// Byte-lane write merge, then drop bits that have no clock behind them
	function automatic logic [DW-1:0] merge_write(
		input logic [DW-1:0]                            old_val,
		input logic [DW-1:0]                            wdata,
		input logic [periph_clock_gate_pkg::BE_W-1:0]   be,
		input logic [DW-1:0]                            impl_mask
	);
		logic [DW-1:0] lane_mask;
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return ((old_val & ~lane_mask) | (wdata & lane_mask)) & impl_mask;
	endfunction

	// Peripheral read data pass only when that peripheral is clocked
	function automatic logic [DW-1:0] gate_read(
		input logic [DW-1:0]                              enables,
		input logic [periph_clock_gate_pkg::INDEX_W-1:0]  index,
		input logic [DW-1:0]                              rdata
	);
		return enables[index] ? rdata : '0;
	endfunction

	// Address decode
	always_comb
	begin
		sel_bus2 = 1'b0;
		sel_bus1 = 1'b0;
		if (av_address == periph_clock_gate_pkg::BUS2_GATE_OFFSET)
		begin
			sel_bus2 = 1'b1;
		end
		else if (av_address == periph_clock_gate_pkg::BUS1_GATE_OFFSET)
		begin
			sel_bus1 = 1'b1;
		end
	end

	// stall on whichever selected bus has its registered busy flag set
	// Busy is registered, so a transfer that starts this cycle stalls from the next one;
	// the peripheral bus master only starts transfers one cycle after raising busy.
	assign stall          = (av_read | av_write) &
	                        ((sel_bus2 & pbus2_busy_reg) | (sel_bus1 & pbus1_busy_reg));
	assign av_waitrequest = stall;
	assign write_taken    = av_write & ~stall;

	// Combinational readback gives a zero-wait answer unless the selected bus is busy (reads stall like writes); unmapped reads give zero
	always_comb
	begin
		av_readdata = periph_clock_gate_pkg::UNMAPPED_READ_VALUE;
		if (sel_bus2)
		begin
			av_readdata = bus2_clock_gate_reg;
		end
		else if (sel_bus1)
		begin
			av_readdata = bus1_clock_gate_reg;
		end
	end

	always_comb
	begin
		bus2_clock_gate_next = bus2_clock_gate_reg;
		bus1_clock_gate_next = bus1_clock_gate_reg;
		pbus2_busy_next      = pbus2_in.busy;
		pbus1_busy_next      = pbus1_in.busy;
		pbus2_rdata_next     = '0;
		pbus1_rdata_next     = '0;
		if (!rst_n)
		begin
			bus2_clock_gate_next = periph_clock_gate_pkg::BUS2_GATE_RESET;
			bus1_clock_gate_next = periph_clock_gate_pkg::BUS1_GATE_RESET;
			pbus2_busy_next      = 1'b0;
			pbus1_busy_next      = 1'b0;
		end
		else
		begin
			pbus2_rdata_next = gate_read(bus2_clock_gate_reg, pbus2_in.rd_index, pbus2_in.rdata);
			pbus1_rdata_next = gate_read(bus1_clock_gate_reg, pbus1_in.rd_index, pbus1_in.rdata);
			if (write_taken && sel_bus2)
			begin
				bus2_clock_gate_next = merge_write(bus2_clock_gate_reg, av_writedata,
				                                   av_byteenable,
				                                   periph_clock_gate_pkg::BUS2_GATE_MASK);
			end
			else if (write_taken && sel_bus1)
			begin
				bus1_clock_gate_next = merge_write(bus1_clock_gate_reg, av_writedata,
				                                   av_byteenable,
				                                   periph_clock_gate_pkg::BUS1_GATE_MASK);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		bus2_clock_gate_reg <= bus2_clock_gate_next;
		bus1_clock_gate_reg <= bus1_clock_gate_next;
		pbus2_busy_reg      <= pbus2_busy_next;
		pbus1_busy_reg      <= pbus1_busy_next;
		pbus2_rdata_reg     <= pbus2_rdata_next;
		pbus1_rdata_reg     <= pbus1_rdata_next;
	end

	assign bus2_gate_en    = bus2_clock_gate_reg;
	assign bus1_gate_en    = bus1_clock_gate_reg;
	assign pbus2_rdata_out = pbus2_rdata_reg;
	assign pbus1_rdata_out = pbus1_rdata_reg;

	// second bus clock bank, one output per bit position
	gated_clock_bank #(
		.N    (DW)
	) u_bus2_gates (
		.clk  (clk),
		.rst_n(rst_n),
		.en   (bus2_clock_gate_reg),
		.gclk (bus2_gclk)
	);

	// shared bit feeds a second clock
	// Kept as its own cell so comparator and system-configuration gates match in delay.
	gated_clock_bank #(
		.N    (2)
	) u_comparator_gate (
		.clk  (clk),
		.rst_n(rst_n),
		.en   ({2{bus2_clock_gate_reg[periph_clock_gate_pkg::SYSCONF_COMPARATOR_CLK_EN_BIT]}}),
		.gclk (comparator_gate)
	);

	assign comparator_gclk = comparator_gate[0];

	gated_clock_bank #(
		.N    (DW)
	) u_bus1_gates (
		.clk  (clk),
		.rst_n(rst_n),
		.en   (bus1_clock_gate_reg),
		.gclk (bus1_gclk)
	);

endmodule // periph_clock_gate

/* File: periph_clock_gate_properties.sv */
`timescale 1ns/1ps
module gate_checker (
	input wire logic                            clk,
	input wire logic                            rst_n,
	input wire logic [7:0]                      av_address,
	input wire logic                            av_read,
	input wire logic                            av_write,
	input wire logic [3:0]                      av_byteenable,
	input wire logic [31:0]                     av_writedata,
	input wire logic [31:0]                     av_readdata,
	input wire logic                            av_waitrequest,
	input wire periph_clock_gate_pkg::pbus_rd_t pbus2_in,
	input wire periph_clock_gate_pkg::pbus_rd_t pbus1_in,
	input wire logic [31:0]                     pbus2_rdata_out,
	input wire logic [31:0]                     pbus1_rdata_out,
	input wire logic [31:0]                     bus2_gate_en,
	input wire logic [31:0]                     bus1_gate_en,
	input wire logic [31:0]                     bus2_gclk,
	input wire logic                            comparator_gclk,
	input wire logic [31:0]                     bus1_gclk
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [31:0] bm;
	logic        req;
	logic        tk;
	assign bm = {{8{av_byteenable[3]}}, {8{av_byteenable[2]}},
		{8{av_byteenable[1]}}, {8{av_byteenable[0]}}};
	assign req = av_read | av_write;
	assign tk = av_write & !av_waitrequest;
	a_bus2_wait: assert property (
		$past(rst_n) && req && av_address == 8'h18 |-> av_waitrequest == $past(pbus2_in.busy))
		else $error("bus2 wait wrong");
	a_bus1_wait: assert property (
		$past(rst_n) && req && av_address == 8'h1c |-> av_waitrequest == $past(pbus1_in.busy))
		else $error("bus1 wait wrong");
	a_unmapped_nowait: assert property (
		req && av_address != 8'h18 && av_address != 8'h1c |-> !av_waitrequest)
		else $error("unmapped stalled");
	a_bus2_merge: assert property (
		tk && av_address == 8'h18 |=> bus2_gate_en == (($past(bus2_gate_en) & ~$past(bm)
		| $past(av_writedata) & $past(bm)) & periph_clock_gate_pkg::BUS2_GATE_MASK))
		else $error("bus2 write wrong");
	a_bus1_merge: assert property (
		tk && av_address == 8'h1c |=> bus1_gate_en == (($past(bus1_gate_en) & ~$past(bm)
		| $past(av_writedata) & $past(bm)) & periph_clock_gate_pkg::BUS1_GATE_MASK))
		else $error("bus1 write wrong");
	a_read_mux: assert property (
		av_read && !av_waitrequest |-> av_readdata == (av_address == 8'h18 ? bus2_gate_en
		: av_address == 8'h1c ? bus1_gate_en : 32'h0000_0000))
		else $error("read data wrong");
	a_gated_read_zero: assert property (
		1'b1 |=> pbus2_rdata_out == ($past(bus2_gate_en[pbus2_in.rd_index]) ? $past(pbus2_in.rdata)
		: 32'h0000_0000) && pbus1_rdata_out == ($past(bus1_gate_en[pbus1_in.rd_index])
		? $past(pbus1_in.rdata) : 32'h0000_0000))
		else $error("gated read wrong");
	a_gclk_low_phase: assert property (
		bus1_gclk == 32'h0000_0000 && bus2_gclk == 32'h0000_0000 && !comparator_gclk)
		else $error("gated clock high while clk low");
	a_gclk_follow_en: assert property (@(negedge clk) disable iff (!rst_n)
		$past(rst_n) && $past(rst_n, 2) |-> bus2_gclk == $past(bus2_gate_en)
		&& bus1_gclk == $past(bus1_gate_en) && comparator_gclk == $past(bus2_gate_en[0]))
		else $error("gated clock not following enable");
	c_stall: cover property (req && av_waitrequest);
	c_write: cover property (tk);
	c_pb_on: cover property (pbus1_rdata_out != 32'h0000_0000);
endmodule // gate_checker

bind periph_clock_gate gate_checker chk (.*);

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic                            clk = 1'b0;
	logic                            rst_n;
	logic [7:0]                      av_address;
	logic                            av_read;
	logic                            av_write;
	logic [3:0]                      av_byteenable;
	logic [31:0]                     av_writedata;
	logic [31:0]                     av_readdata;
	logic                            av_waitrequest;
	periph_clock_gate_pkg::pbus_rd_t pbus2_in;
	periph_clock_gate_pkg::pbus_rd_t pbus1_in;
	logic [31:0]                     pbus2_rdata_out;
	logic [31:0]                     pbus1_rdata_out;
	logic [31:0]                     bus2_gate_en;
	logic [31:0]                     bus1_gate_en;
	logic [31:0]                     bus2_gclk;
	logic                            comparator_gclk;
	logic [31:0]                     bus1_gclk;
	logic [31:0]                     m1;
	logic [31:0]                     m2;
	logic [31:0]                     rnd;
	logic                            pb_v;
	logic                            pb_seen = 1'b0;
	logic [31:0]                     q_rd[$];
	logic [63:0]                     q_pb[$];
	int                              n_mismatch = 0;
	int                              checks_done = 0;
	int                              w;
	periph_clock_gate dut (.*);
	always #2.5 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		logic [31:0] k;
		logic        wt;
		k = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		if (!we)
			q_rd.push_back(a == 8'h18 ? m2 : a == 8'h1c ? m1 : 32'h0000_0000);
		av_address <= a;
		av_write <= we;
		av_read <= !we;
		av_byteenable <= be;
		av_writedata <= d;
		w = 0;
		// Waitrequest is sampled at the rising edge only; NBAs from that edge land later
		do
		begin
			@(posedge clk);
			wt = av_waitrequest;
			w += (wt === 1'b1);
		end
		while (wt === 1'b1 && w < 100);
		// A request never accepted is a failure, not a silent exit
		if (wt !== 1'b0)
			n_mismatch++;
		if (we && a == 8'h18)
			m2 = (m2 & ~k | d & k) & periph_clock_gate_pkg::BUS2_GATE_MASK;
		if (we && a == 8'h1c)
			m1 = (m1 & ~k | d & k) & periph_clock_gate_pkg::BUS1_GATE_MASK;
	endtask
	task automatic rel;
		av_read <= 1'b0;
		av_write <= 1'b0;
		@(posedge clk);
	endtask
	// Busy stays up for four edges; one-cycle flag lag gives three waits
	task automatic stall(input logic [7:0] a, input logic [7:0] o);
		pbus2_in.busy <= (a == 8'h18);
		pbus1_in.busy <= (a == 8'h1c);
		fork
			begin
				repeat (4) @(posedge clk);
				pbus2_in.busy <= 1'b0;
				pbus1_in.busy <= 1'b0;
			end
			begin
				@(posedge clk);
				bus(1'b0, o, 4'hf, 32'h0000_0000);
				cmp("other_bus_waits", 32'h0000_0000, w);
				bus(1'b1, a, 4'hf, 32'hffff_ffff);
				cmp("busy_bus_waits", 32'h0000_0003, w);
			end
		join
		rel();
	endtask
	always @(posedge clk)
		pb_seen <= pb_v;
	always @(negedge clk)
	begin
		if (av_read && !av_waitrequest && q_rd.size() > 0)
			cmp("readdata", q_rd.pop_front(), av_readdata);
		if (pb_seen && q_pb.size() > 0)
		begin
			cmp("pbus2_rdata", q_pb[0][63:32], pbus2_rdata_out);
			cmp("pbus1_rdata", q_pb.pop_front()[31:0], pbus1_rdata_out);
		end
	end
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Whole run needs about 140 cycles; this leaves ample margin
	initial
	begin
		#20000;
		n_mismatch++;
		results();
	end
	initial
	begin
		{rst_n, av_read, av_write, pb_v, av_address, av_byteenable, av_writedata} = '0;
		pbus2_in = '0;
		pbus1_in = '0;
		{m1, m2} = '0;
		rnd = 32'h0000_0056;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b1, 8'h14, 4'hf, 32'hffff_ffff);
		foreach (m1[i])
			if (i < 3)
				bus(1'b0, i == 0 ? 8'h18 : i == 1 ? 8'h1c : 8'h14, 4'hf, 32'h0000_0000);
		rel();
		$display("test reset_values done");
		for (int j = 0; j < 40; j++)
		begin
			rnd = lfsr(rnd);
			bus(1'b1, rnd[8] ? 8'h18 : 8'h1c, j < 2 ? 4'hf : rnd[3:0], lfsr(rnd));
			bus(1'b0, rnd[8] ? 8'h18 : 8'h1c, 4'hf, 32'h0000_0000);
		end
		rel();
		$display("test byte_writes done");
		for (int i = 0; i < 32; i++)
		begin
			rnd = lfsr(rnd);
			pbus2_in.rd_index <= i[4:0];
			pbus1_in.rd_index <= i[4:0];
			pbus2_in.rdata <= rnd;
			pbus1_in.rdata <= ~rnd;
			pb_v <= 1'b1;
			q_pb.push_back({m2[i] ? rnd : 32'h0000_0000, m1[i] ? ~rnd : 32'h0000_0000});
			@(posedge clk);
		end
		pb_v <= 1'b0;
		@(posedge clk);
		$display("test gated_reads done");
		stall(8'h18, 8'h1c);
		stall(8'h1c, 8'h18);
		$display("test bus_stall done");
		results();
	end
endmodule // tb_top
